// *** core/ucp_pkg.sv ***
// Package for the serial port control and data block.
// Assumes one clock domain and a byte-wide register port.
package ucp_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h99;
  localparam logic [7:0] ADDR_BAUD_RELOAD = 8'h9a;
  localparam logic [7:0] ADDR_BAUD_CFG = 8'h9b;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h9c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h9d;
  localparam int BIT_MODE = 7;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_MPE = 5;
  localparam int BIT_REN = 4;
  localparam int BIT_TB8 = 3;
  localparam int BIT_RB8 = 2;
  localparam int BIT_TC = 1;
  localparam int BIT_RC = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] PRE_DIV12 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV48 = 2'h2;
  localparam logic [1:0] PRE_DIV8 = 2'h3;
  localparam logic [5:0] DIV4 = 6'h04;
  localparam logic [5:0] DIV8 = 6'h08;
  localparam logic [5:0] DIV12 = 6'h0c;
  localparam logic [5:0] DIV48 = 6'h30;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] OVF_PER_BIT = 4'h2;
  localparam logic [3:0] HALF_BIT = 4'h1;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ucp_bus_type;

  typedef struct packed {
    logic mode9;
    logic mpe;
    logic ren;
    logic tb8;
  } ucp_cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b011,
    ST_NINTH = 3'b010,
    ST_STOP = 3'b110
  } ucp_state_type;
endpackage

// *** core/ucp_baud.sv ***
// Baud tick generator: an 8-bit auto-reload timer on a prescaled clock, or on mclk directly when clock_select is set.
// Assumes software loads the reload and prescale fields of the port.
`timescale 1ns/1ns
`default_nettype none
module ucp_baud (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reload,
  input wire logic clock_select,
  input wire logic [1:0] prescale,
  output logic tick
);
  logic [5:0] pre_cnt;
  logic [5:0] next_pre_cnt;
  logic [7:0] tmr;
  logic [7:0] next_tmr;
  logic next_tick;
  logic [5:0] div;
  logic pre_en;

  always_comb begin
    case (prescale)
      ucp_pkg::PRE_DIV12: div = ucp_pkg::DIV12;
      ucp_pkg::PRE_DIV4: div = ucp_pkg::DIV4;
      ucp_pkg::PRE_DIV48: div = ucp_pkg::DIV48;
      default: div = ucp_pkg::DIV8;
    endcase
    pre_en = clock_select || (pre_cnt == div - 6'h01);
    next_pre_cnt = (clock_select || pre_en) ? 6'h00 : pre_cnt + 6'h01;
    next_tick = 1'b0;
    next_tmr = tmr;
    if (pre_en) begin
      if (tmr == 8'hff) begin
        next_tmr = reload;
        next_tick = 1'b1;
      end else begin
        next_tmr = tmr + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 6'h00;
      tmr <= 8'h00;
      tick <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      tmr <= next_tmr;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// *** core/ucp_uart.sv ***
// Serial port control register, data buffer, transmitter and receiver.
// Assumes a byte register port on mclk and an asynchronous rx pin.
// Function
// - Receiver accepts frames only while the receive enable bit is set.
// - In 9-bit mode the ninth transmit bit is sent as bit nine.
// - Ninth receive bit takes stop bit (8-bit) or ninth data bit (9-bit).
// - Transmit flag sets after data bit eight, or at stop start in 9-bit.
// - Either completion flag raises the port interrupt when enabled.
// - Receive flag sets when the stop bit is sampled.
// - Data address writes the transmit register, reads the receive latch.
// - Writing the data address starts a transmission at once.
// - Reading the data address returns the receive latch.
// - Mode bit selects 8-bit frames at 0 and 9-bit frames at 1.
// - With multiprocessor enable, receive needs stop or ninth bit high.
// - A frame is kept only if the receive flag is still clear.
// - Frame is start, eight data bits LSB first, ninth bit in 9-bit mode only, stop bit.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module ucp_uart (
  input wire logic mclk,
  input wire logic rst_n,
  input wire ucp_pkg::ucp_bus_type bus,
  output logic [7:0] rdata,
  input wire logic rx,
  output logic tx,
  output logic irq
);
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] rx_latch;
  logic [7:0] next_rx_latch;
  logic [7:0] reload;
  logic [7:0] next_reload;
  logic [2:0] bcfg;
  logic [2:0] next_bcfg;
  logic [1:0] irq_st;
  logic [1:0] next_irq_st;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic [7:0] next_rdata;
  logic next_irq;
  logic tick;
  logic rx_s1;
  logic rx_s2;
  logic rx_prev;
  ucp_pkg::ucp_cfg_type cfg;

  ucp_pkg::ucp_state_type tx_st;
  ucp_pkg::ucp_state_type next_tx_st;
  logic [7:0] tx_sh;
  logic [7:0] next_tx_sh;
  logic [3:0] tx_cnt;
  logic [3:0] next_tx_cnt;
  logic [3:0] tx_ph;
  logic [3:0] next_tx_ph;
  logic next_tx;
  logic tx_done;

  ucp_pkg::ucp_state_type rx_st;
  ucp_pkg::ucp_state_type next_rx_st;
  logic [7:0] rx_sh;
  logic [7:0] next_rx_sh;
  logic [3:0] rx_cnt;
  logic [3:0] next_rx_cnt;
  logic [3:0] rx_ph;
  logic [3:0] next_rx_ph;
  logic rx_ninth;
  logic next_rx_ninth;
  logic rx_done;
  logic rx_keep;
  logic rx_bit9;

  wire logic wr_ctrl = bus.wr && bus.addr == ucp_pkg::ADDR_CONTROL;
  wire logic wr_data = bus.wr && bus.addr == ucp_pkg::ADDR_DATA;

  assign cfg = '{mode9: ctrl[ucp_pkg::BIT_MODE], mpe: ctrl[ucp_pkg::BIT_MPE],
                 ren: ctrl[ucp_pkg::BIT_REN], tb8: ctrl[ucp_pkg::BIT_TB8]};

  ucp_baud u_baud (
    .mclk(mclk),
    .rst_n(rst_n),
    .reload(reload),
    .clock_select(bcfg[2]),
    .prescale(bcfg[1:0]),
    .tick(tick)
  );

  // Two-flop synchroniser on the receive pin, plus a delayed copy that finds falling edges.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1 <= rx;
      rx_s2 <= rx_s1;
      rx_prev <= rx_s2;
    end
  end

  // Transmitter: each data, ninth and stop bit lasts two timer overflows; the start bit ends at the second overflow after the write.
  always_comb begin
    next_tx_st = tx_st;
    next_tx_sh = tx_sh;
    next_tx_cnt = tx_cnt;
    next_tx_ph = tx_ph;
    next_tx = tx;
    tx_done = 1'b0;
    if (wr_data) begin
      next_tx_st = ucp_pkg::ST_START;
      next_tx_sh = bus.wdata;
      next_tx_ph = 4'h0;
      next_tx = 1'b0;
    end else if (tick && tx_st != ucp_pkg::ST_IDLE) begin
      next_tx_ph = tx_ph + 4'h1;
      if (tx_ph == ucp_pkg::OVF_PER_BIT - 4'h1) begin
        next_tx_ph = 4'h0;
        case (tx_st)
          ucp_pkg::ST_START: begin
            next_tx_st = ucp_pkg::ST_DATA;
            next_tx = tx_sh[0];
            next_tx_cnt = 4'h1;
          end
          ucp_pkg::ST_DATA: begin
            if (tx_cnt == ucp_pkg::DATA_BITS) begin
              if (cfg.mode9) begin
                next_tx_st = ucp_pkg::ST_NINTH;
                next_tx = cfg.tb8;
              end else begin
                next_tx_st = ucp_pkg::ST_STOP;
                next_tx = 1'b1;
                tx_done = 1'b1;
              end
            end else begin
              next_tx = tx_sh[tx_cnt[2:0]];
              next_tx_cnt = tx_cnt + 4'h1;
            end
          end
          ucp_pkg::ST_NINTH: begin
            next_tx_st = ucp_pkg::ST_STOP;
            next_tx = 1'b1;
            tx_done = 1'b1;
          end
          default: begin
            next_tx_st = ucp_pkg::ST_IDLE;
            next_tx = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st <= ucp_pkg::ST_IDLE;
      tx_sh <= ucp_pkg::DATA_RESET;
      tx_cnt <= 4'h0;
      tx_ph <= 4'h0;
      tx <= 1'b1;
    end else begin
      tx_st <= next_tx_st;
      tx_sh <= next_tx_sh;
      tx_cnt <= next_tx_cnt;
      tx_ph <= next_tx_ph;
      tx <= next_tx;
    end
  end

  // Receiver: samples mid-bit, one overflow after each edge of the bit grid.
  always_comb begin
    next_rx_st = rx_st;
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_rx_ph = rx_ph;
    next_rx_ninth = rx_ninth;
    rx_done = 1'b0;
    rx_bit9 = cfg.mode9 ? rx_ninth : rx_s2;
    if (!cfg.ren) begin
      next_rx_st = ucp_pkg::ST_IDLE;
    end else if (rx_st == ucp_pkg::ST_IDLE) begin
      // Only a falling edge opens a frame, so a stop bit held low cannot start one.
      if (!rx_s2 && rx_prev) begin
        next_rx_st = ucp_pkg::ST_START;
        next_rx_ph = 4'h0;
      end
    end else if (tick) begin
      next_rx_ph = rx_ph + 4'h1;
      if (rx_ph == ucp_pkg::HALF_BIT - 4'h1 && rx_st == ucp_pkg::ST_START) begin
        next_rx_ph = 4'h0;
        next_rx_cnt = 4'h0;
        next_rx_st = rx_s2 ? ucp_pkg::ST_IDLE : ucp_pkg::ST_DATA;
      end else if (rx_ph == ucp_pkg::OVF_PER_BIT - 4'h1) begin
        next_rx_ph = 4'h0;
        case (rx_st)
          ucp_pkg::ST_DATA: begin
            next_rx_sh = {rx_s2, rx_sh[7:1]};
            next_rx_cnt = rx_cnt + 4'h1;
            if (rx_cnt == ucp_pkg::DATA_BITS - 4'h1) begin
              next_rx_st = cfg.mode9 ? ucp_pkg::ST_NINTH : ucp_pkg::ST_STOP;
            end
          end
          ucp_pkg::ST_NINTH: begin
            next_rx_ninth = rx_s2;
            next_rx_st = ucp_pkg::ST_STOP;
          end
          ucp_pkg::ST_STOP: begin
            next_rx_st = ucp_pkg::ST_IDLE;
            rx_done = 1'b1;
          end
          default: next_rx_st = ucp_pkg::ST_IDLE;
        endcase
      end
    end
    rx_keep = rx_done && !ctrl[ucp_pkg::BIT_RC] && (!cfg.mpe || rx_bit9);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st <= ucp_pkg::ST_IDLE;
      rx_sh <= ucp_pkg::DATA_RESET;
      rx_cnt <= 4'h0;
      rx_ph <= 4'h0;
      rx_ninth <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      rx_ph <= next_rx_ph;
      rx_ninth <= next_rx_ninth;
    end
  end

  // Registers; hardware sets of the flags win over software writes.
  always_comb begin
    next_ctrl = ctrl;
    next_rx_latch = rx_latch;
    next_reload = reload;
    next_bcfg = bcfg;
    next_irq_st = irq_st;
    next_irq_mask = irq_mask;
    if (wr_ctrl) begin
      next_ctrl = bus.wdata;
      next_ctrl[ucp_pkg::BIT_UNUSED] = 1'b1;
    end
    if (bus.wr && bus.addr == ucp_pkg::ADDR_BAUD_RELOAD) next_reload = bus.wdata;
    if (bus.wr && bus.addr == ucp_pkg::ADDR_BAUD_CFG) next_bcfg = bus.wdata[2:0];
    if (bus.wr && bus.addr == ucp_pkg::ADDR_IRQ_MASK) next_irq_mask = bus.wdata[1:0];
    if (bus.wr && bus.addr == ucp_pkg::ADDR_IRQ_STATUS) begin
      next_irq_st = irq_st & ~bus.wdata[1:0];
    end
    if (rx_keep) begin
      next_rx_latch = rx_sh;
      next_ctrl[ucp_pkg::BIT_RB8] = rx_bit9;
      next_ctrl[ucp_pkg::BIT_RC] = 1'b1;
      next_irq_st[ucp_pkg::BIT_RC] = 1'b1;
    end
    if (tx_done) begin
      next_ctrl[ucp_pkg::BIT_TC] = 1'b1;
      next_irq_st[ucp_pkg::BIT_TC] = 1'b1;
    end
    next_irq = |(next_irq_st & next_irq_mask);
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        ucp_pkg::ADDR_CONTROL: next_rdata = ctrl;
        ucp_pkg::ADDR_DATA: next_rdata = rx_latch;
        ucp_pkg::ADDR_BAUD_RELOAD: next_rdata = reload;
        ucp_pkg::ADDR_BAUD_CFG: next_rdata = {5'h00, bcfg};
        ucp_pkg::ADDR_IRQ_STATUS: next_rdata = {6'h00, irq_st};
        ucp_pkg::ADDR_IRQ_MASK: next_rdata = {6'h00, irq_mask};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= ucp_pkg::CONTROL_RESET;
      rx_latch <= ucp_pkg::DATA_RESET;
      reload <= ucp_pkg::RELOAD_RESET;
      bcfg <= ucp_pkg::CFG_RESET;
      irq_st <= ucp_pkg::IRQ_RESET;
      irq_mask <= ucp_pkg::IRQ_RESET;
      rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      rx_latch <= next_rx_latch;
      reload <= next_reload;
      bcfg <= next_bcfg;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire

// *** dv/ucp_uart_checker.sv ***
// Port checker of the serial port block.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ucp_uart_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire ucp_pkg::ucp_bus_type bus,
  input wire logic [7:0] rdata,
  input wire logic rx,
  input wire logic tx,
  input wire logic irq
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  AST_RESET_IDLE: assert property (!$past(rst_n) |-> tx && !irq && rdata == 8'h00)
    else $error("port not idle after reset");
  AST_RDATA_QUIET: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data without a read");
  AST_UNMAPPED_ZERO: assert property (bus.rd && (bus.addr < ucp_pkg::ADDR_CONTROL ||
    bus.addr > ucp_pkg::ADDR_IRQ_MASK) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CTRL_FIXED_ONE: assert property (bus.rd && bus.addr == ucp_pkg::ADDR_CONTROL
    |=> rdata[ucp_pkg::BIT_UNUSED])
    else $error("control bit six not one");
  AST_TX_START: assert property (bus.wr && bus.addr == ucp_pkg::ADDR_DATA |=> !tx [*2])
    else $error("data write did not start a frame");
  AST_BIT_HOLD: assert property ($changed(tx) && !bus.wr |=> $stable(tx))
    else $error("serial bit shorter than two ticks");
  AST_IRQ_HOLD: assert property (!bus.wr ##1 (irq && !bus.wr) |=> irq)
    else $error("interrupt dropped without a write");
  AST_MASK_OFF: assert property (bus.wr && bus.addr == ucp_pkg::ADDR_IRQ_MASK &&
    bus.wdata == 8'h00 |=> ##1 !irq [*3])
    else $error("masked interrupt still high");
endmodule
bind ucp_uart ucp_uart_checker u_chk (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .rx(rx), .tx(tx), .irq(irq));
`default_nettype wire

// *** dv/ucp_node.sv ***
// Remote serial node: drives the receive pin and decodes the transmit pin.
// Assumes a fixed bit time of BIT clocks; the receive pin idles high.
`timescale 1ns/1ns
`default_nettype none
module ucp_node #(
  parameter int BIT = 8
) (
  input wire logic mclk,
  input wire logic tx,
  output logic rx
);
  initial rx = 1'b1;
  task automatic send(input logic [7:0] d, input logic h9, input logic b9, input logic st);
    logic [10:0] f;
    f = {st, b9, d, 1'b0};
    @(posedge mclk);
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || h9) begin
        rx <= f[i];
        repeat (BIT) @(posedge mclk);
      end
    end
    rx <= 1'b1;
  endtask
  // The first data bit must be one: its rising edge fixes the bit phase.
  task automatic recv(output logic [9:0] got);
    int n;
    n = 0;
    while (tx !== 1'b0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    while (tx !== 1'b1 && n < 600) begin
      @(posedge mclk);
      n++;
    end
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      got[i] = tx;
      repeat (BIT) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// *** dv/test_ucp_uart.sv ***
// Testbench of the serial port block through its register port.
// Assumes the baud timer is set so that one bit lasts eight clocks.
`timescale 1ns/1ns
`default_nettype none
module test_ucp_uart;
  logic mclk;
  logic rst_n;
  ucp_pkg::ucp_bus_type bus;
  logic [7:0] rdata;
  logic rx;
  logic tx;
  logic irq;
  int fail_count;
  int n_compared;
  ucp_uart u_dut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .rx(rx), .tx(tx),
    .irq(irq));
  ucp_node #(.BIT(8)) u_node (.mclk(mclk), .tx(tx), .rx(rx));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    chk($sformatf("reg %h", a), {2'b00, e}, {2'b00, rdata});
  endtask
  task automatic ck_irq(input logic e);
    repeat (3) @(negedge mclk);
    chk("irq", {9'h000, e}, {9'h000, irq});
  endtask
  task automatic txf(input logic [7:0] d, input logic m9, input logic t8);
    logic [9:0] got;
    wr(8'h99, d);
    u_node.recv(got);
    chk("frame", {1'b1, m9 ? t8 : 1'b1, d}, got);
  endtask
  task automatic rxf(input logic [7:0] d, input logic h9, input logic b9, input logic st,
    input logic [7:0] ec, input logic [7:0] ed);
    u_node.send(d, h9, b9, st);
    rc(8'h98, ec);
    rc(8'h99, ed);
  endtask
  // Programs a baud setting and counts the clocks of the first data bit of 0x55.
  task automatic bt(input logic [7:0] cf, input logic [7:0] rl, input int e);
    int n;
    n = 0;
    wr(8'h9b, cf);
    wr(8'h9a, rl);
    wr(8'h99, 8'h55);
    while (tx !== 1'b0) begin
      @(posedge mclk);
    end
    while (tx !== 1'b1) begin
      @(posedge mclk);
    end
    while (tx !== 1'b0) begin
      @(posedge mclk);
      n++;
    end
    chk("bit time", e[9:0], n[9:0]);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    complete_run();
  end
  initial begin
    fail_count = 0;
    n_compared = 0;
    bus = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rc(8'h98, 8'h40);
    rc(8'h99, 8'h00);
    rc(8'h55, 8'h00);
    wr(8'h9a, 8'hfc);
    wr(8'h9b, 8'h04);
    wr(8'h9d, 8'h03);
    txf(8'ha5, 1'b0, 1'b0);
    rc(8'h98, 8'h42);
    repeat (20) @(negedge mclk);
    ck_irq(1'b1);
    rc(8'h99, 8'h00);
    wr(8'h98, 8'h00);
    wr(8'h9c, 8'h03);
    ck_irq(1'b0);
    for (int t = 0; t < 2; t++) begin
      wr(8'h98, {4'h8, t[0], 3'h0});
      txf(8'h3b, 1'b1, t[0]);
      rc(8'h98, {4'hc, t[0], 3'h2});
    end
    wr(8'h98, 8'h00);
    wr(8'h9c, 8'h03);
    u_node.send(8'h5a, 1'b0, 1'b0, 1'b1);
    rc(8'h98, 8'h40);
    wr(8'h98, 8'h10);
    rxf(8'h5a, 1'b0, 1'b0, 1'b1, 8'h55, 8'h5a);
    ck_irq(1'b1);
    rc(8'h9c, 8'h01);
    wr(8'h9d, 8'h00);
    ck_irq(1'b0);
    wr(8'h9d, 8'h03);
    rxf(8'h33, 1'b0, 1'b0, 1'b1, 8'h55, 8'h5a);
    wr(8'h98, 8'h30);
    wr(8'h9c, 8'h03);
    rxf(8'h77, 1'b0, 1'b0, 1'b0, 8'h70, 8'h5a);
    rxf(8'h77, 1'b0, 1'b0, 1'b1, 8'h75, 8'h77);
    wr(8'h98, 8'h90);
    rxf(8'hc3, 1'b1, 1'b0, 1'b1, 8'hd1, 8'hc3);
    wr(8'h98, 8'hb0);
    rxf(8'h11, 1'b1, 1'b0, 1'b1, 8'hf0, 8'hc3);
    rxf(8'h22, 1'b1, 1'b1, 1'b1, 8'hf5, 8'h22);
    wr(8'h98, 8'h10);
    fork
      txf(8'ha5, 1'b0, 1'b0);
      u_node.send(8'h4c, 1'b0, 1'b0, 1'b1);
    join
    rc(8'h99, 8'h4c);
    bt(8'h04, 8'hcb, 106);
    bt(8'h04, 8'hd0, 96);
    bt(8'h01, 8'h96, 848);
    complete_run();
  end
endmodule
`default_nettype wire
